// ### rdem_pkg.sv
/*
  Constants for the receive dynamic delay and eye monitor block: register
  offsets, field positions, reset values and the guard window decode.
  Assumes a 32-bit classic Wishbone register bus and at most eight lanes.
*/
// ============================================================
// Operation
// RQ1: The delay setting changes only on a rising edge of the tap step input, never on a level.
// RQ2: Each step pulse moves the delay by one increment, up when direction is high, down when low.
// RQ3: Tap restore returns the delay to its static initial setting at once, without a clock edge.
// RQ4: The limit-hit output is high whenever the delay equals the chain minimum or maximum.
// RQ5: Steps past the minimum or maximum leave the delay unchanged, so it saturates.
// RQ6: Each lane raises an early flag when its data edge lies close before the clock edge.
// RQ7: On an early flag the training logic steps that lane's delay down.
// RQ8: Each lane raises a late flag when its data edge lies close after the clock edge.
// RQ9: On a late flag the training logic steps that lane's delay up.
// RQ10: A lane's flag-clear input clears both its early and late flags.
// RQ11: The training logic pulses flag-clear after it has stepped the delay for the old flags.
// RQ12: A three-bit guard code selects a spacing of 1, 2, 3, 4, 5, 6 or 8 increments, changeable live.
// RQ13: Early or late flags are raised only when the edge is closer than the selected spacing.
// RQ14: Limit-hit drops once an opposite step or a restore moves the delay off the chain end.
// RQ15: Step rising edges are detected on the receive clock, one increment per pulse.
package rdem_pkg;

  // ============================================================
  // Sizes
  localparam int LANES_DEF = 4;
  localparam int TAP_W_DEF = 7;
  localparam int OFS_W_DEF = 5;
  localparam int GUARD_W = 3;

  // ============================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_TAP_BASE = 8'h10;

  // ============================================================
  // Field positions; status, irq status and irq mask share a layout
  localparam int CTRL_GUARD_LSB = 0;
  localparam int FLD_LIMIT_LSB = 0;
  localparam int FLD_EARLY_LSB = 8;
  localparam int FLD_LATE_LSB = 16;

  // ============================================================
  // Reset values
  localparam logic [GUARD_W-1:0] GUARD_RST = 3'h0;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;

  // ============================================================
  // Guard code to spacing in increments; code 7 repeats the widest
  function automatic logic [3:0] guard_spacing(input logic [GUARD_W-1:0] code);
    logic [3:0] s;
    s = 4'h8;
    unique case (code)
      3'h0: s = 4'h1;
      3'h1: s = 4'h2;
      3'h2: s = 4'h3;
      3'h3: s = 4'h4;
      3'h4: s = 4'h5;
      3'h5: s = 4'h6;
      3'h6: s = 4'h8;
      3'h7: s = 4'h8;
    endcase
    return s;
  endfunction

endpackage

// ### rdem_lane_if.sv
/*
  Per-lane link between the control logic and one delay chain controller.
  Assumes step is a one-cycle pulse on the receive clock and restore is
  asynchronous.
*/
interface rdem_lane_if #(
  parameter int TAP_W = rdem_pkg::TAP_W_DEF
);
  logic step;
  logic up;
  logic restore;
  logic [TAP_W-1:0] tap;
  logic limit;

  modport lane (input step, input up, input restore, output tap, output limit);
  modport ctl (output step, output up, output restore, input tap, input limit);
endinterface

// ### rdem_lane.sv
/*
  One lane's delay chain controller: saturating tap counter with an
  asynchronous restore to the static setting, and a registered limit flag.
  Assumes step and up are aligned on the clock.
*/
module rdem_lane #(
  parameter int TAP_W = rdem_pkg::TAP_W_DEF,
  parameter logic [TAP_W-1:0] INIT_TAP = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control side
  rdem_lane_if.lane lif
);

  localparam logic [TAP_W-1:0] TAP_MAX = '1;
  localparam logic TAP_MIN_END = (INIT_TAP == '0);
  localparam logic INIT_LIM = TAP_MIN_END || (INIT_TAP == TAP_MAX);

  typedef struct packed {
    logic [TAP_W-1:0] tap;
    logic limit;
  } rdem_lane_state_t;

  rdem_lane_state_t lane_r;
  rdem_lane_state_t lane_nxt;
  logic arst_n;

  // Restore acts like a reset; its release is not synchronised
  assign arst_n = rst_n & ~lif.restore; // [RQ3]

  // ============================================================
  // Saturating counter
  always_comb begin
    lane_nxt = lane_r;
    if (lif.step) begin // [RQ1]
      if (lif.up && (lane_r.tap != TAP_MAX)) begin // [RQ2] [RQ5]
        lane_nxt.tap = lane_r.tap + 1'b1;
      end else if (!lif.up && (lane_r.tap != '0)) begin // [RQ2] [RQ5]
        lane_nxt.tap = lane_r.tap - 1'b1;
      end
    end
    lane_nxt.limit = (lane_nxt.tap == '0) || (lane_nxt.tap == TAP_MAX); // [RQ4] [RQ14]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_r <= '{tap: INIT_TAP, limit: INIT_LIM}; // [RQ3]
    end else begin
      lane_r <= lane_nxt;
    end
  end

  assign lif.tap = lane_r.tap;
  assign lif.limit = lane_r.limit;

endmodule // rdem_lane

// ### rdem_top.sv
/*
  Receive dynamic delay control and eye monitor, one delay chain per lane,
  with a classic Wishbone register slave and a level interrupt.
  Assumes fabric training logic on MCLK drives flag clears and edge reports;
  tap step and direction may come from anywhere and are synchronised.
*/
// The Wishbone slave port and the placing of the registers were left to the implementer.
module rdem_top #(
  parameter int LANES = rdem_pkg::LANES_DEF,
  parameter int TAP_W = rdem_pkg::TAP_W_DEF,
  parameter int OFS_W = rdem_pkg::OFS_W_DEF,
  parameter logic [TAP_W-1:0] INIT_TAP = '0
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Delay chain control
  input wire logic [LANES-1:0] TAP_STEP,
  input wire logic [LANES-1:0] TAP_DIR,
  input wire logic [LANES-1:0] TAP_RESTORE,
  output logic [LANES-1:0] TAP_LIMIT_HIT,
  // Eye monitor
  input wire logic [LANES-1:0] EDGE_VLD,
  input wire logic [LANES*OFS_W-1:0] EDGE_OFS,
  input wire logic [LANES-1:0] FLAG_CLR,
  output logic [LANES-1:0] EYE_EARLY,
  output logic [LANES-1:0] EYE_LATE,
  // Interrupt
  output logic IRQ
);

  // ============================================================
  // State
  typedef struct packed {
    logic [LANES-1:0] step_m;
    logic [LANES-1:0] step_s;
    logic [LANES-1:0] step_q;
    logic [LANES-1:0] dir_m;
    logic [LANES-1:0] dir_s;
    logic [LANES-1:0] early;
    logic [LANES-1:0] late;
    logic [LANES-1:0] lim_q;
    logic [rdem_pkg::GUARD_W-1:0] guard;
    logic [31:0] irq_stat;
    logic [31:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } rdem_state_t;

  rdem_state_t st_r;
  rdem_state_t st_nxt;

  // ============================================================
  // Lane wiring
  logic [LANES-1:0] step_pulse;
  logic [LANES-1:0] lim_v;
  logic [LANES*TAP_W-1:0] tap_v;

  // Edge of the synchronised level, so a held step moves once
  assign step_pulse = st_r.step_s & ~st_r.step_q; // [RQ1] [RQ15]

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      rdem_lane_if #(.TAP_W(TAP_W)) lif ();

      assign lif.step = step_pulse[gi];
      assign lif.up = st_r.dir_s[gi]; // [RQ2]
      assign lif.restore = TAP_RESTORE[gi]; // [RQ3]
      assign lim_v[gi] = lif.limit;
      assign tap_v[gi*TAP_W +: TAP_W] = lif.tap;

      rdem_lane #(
        .TAP_W(TAP_W),
        .INIT_TAP(INIT_TAP)
      ) u_lane (
        .clk(MCLK),
        .rst_n(RESETN),
        .lif(lif)
      );
    end
  endgenerate

  // ============================================================
  // Valid bit masks of the shared status layout
  function automatic logic [31:0] lane_field(input logic [LANES-1:0] v, input int lsb);
    logic [31:0] f;
    f = 32'h0000_0000;
    f[lsb +: LANES] = v;
    return f;
  endfunction

  localparam logic [LANES-1:0] ALL_LANES = '1;
  // Limit history starts at the lanes' reset level, so release makes no false event
  localparam logic [LANES-1:0] INIT_LIMS = ((INIT_TAP == '0) || (INIT_TAP == '1)) ? '1 : '0;

  // ============================================================
  // Next state
  always_comb begin
    logic [3:0] spc;
    logic signed [OFS_W-1:0] ofs;
    logic [OFS_W:0] mag;
    logic [LANES-1:0] hit_early;
    logic [LANES-1:0] hit_late;
    logic [31:0] ev;
    logic [31:0] bmask;
    logic [31:0] w1c;
    logic [31:0] valid;
    logic req;
    int idx;
    spc = 4'h0;
    ofs = '0;
    mag = '0;
    hit_early = '0;
    hit_late = '0;
    ev = 32'h0000_0000;
    bmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    w1c = 32'h0000_0000;
    req = 1'b0;
    idx = 0;
    valid = lane_field(ALL_LANES, rdem_pkg::FLD_LIMIT_LSB)
          | lane_field(ALL_LANES, rdem_pkg::FLD_EARLY_LSB)
          | lane_field(ALL_LANES, rdem_pkg::FLD_LATE_LSB);
    st_nxt = st_r;

    // Two-flop synchronisers for step and direction
    st_nxt.step_m = TAP_STEP; // [RQ15]
    st_nxt.step_s = st_r.step_m;
    st_nxt.step_q = st_r.step_s;
    st_nxt.dir_m = TAP_DIR;
    st_nxt.dir_s = st_r.dir_m;

    // Eye monitor: signed offset of data edge from clock edge, in taps
    spc = rdem_pkg::guard_spacing(st_r.guard); // [RQ12]
    for (int i = 0; i < LANES; i++) begin
      ofs = EDGE_OFS[i*OFS_W +: OFS_W];
      if (ofs < 0) begin
        mag = (OFS_W + 1)'(-$signed({ofs[OFS_W-1], ofs}));
        hit_early[i] = EDGE_VLD[i] && (mag < {{(OFS_W-3){1'b0}}, spc}); // [RQ6] [RQ13]
      end else begin
        mag = {1'b0, ofs};
        hit_late[i] = EDGE_VLD[i] && (mag < {{(OFS_W-3){1'b0}}, spc}); // [RQ8] [RQ13]
      end
    end

    // A report in the clearing cycle survives the clear
    st_nxt.early = hit_early | (st_r.early & ~FLAG_CLR); // [RQ6] [RQ10]
    st_nxt.late = hit_late | (st_r.late & ~FLAG_CLR); // [RQ8] [RQ10]

    // Interrupt events: new flag raised, chain end reached
    st_nxt.lim_q = lim_v;
    ev = lane_field(hit_early & ~st_r.early, rdem_pkg::FLD_EARLY_LSB)
       | lane_field(hit_late & ~st_r.late, rdem_pkg::FLD_LATE_LSB)
       | lane_field(lim_v & ~st_r.lim_q, rdem_pkg::FLD_LIMIT_LSB);

    // Wishbone: one wait state, ack dropped after one cycle
    // Writes land at the edge where the master samples ack
    req = CYC_I && STB_I && !st_r.ack;
    st_nxt.ack = req;
    st_nxt.dat = 32'h0000_0000;
    if (CYC_I && STB_I && WE_I && st_r.ack) begin
      unique case (ADR_I)
        rdem_pkg::REG_CTRL: begin
          if (SEL_I[0]) begin
            st_nxt.guard = DAT_I[rdem_pkg::CTRL_GUARD_LSB +: rdem_pkg::GUARD_W]; // [RQ12]
          end
        end
        rdem_pkg::REG_IRQ_MASK: begin
          st_nxt.irq_mask = ((st_r.irq_mask & ~bmask) | (DAT_I & bmask)) & valid;
        end
        rdem_pkg::REG_IRQ_STAT: begin
          w1c = DAT_I & bmask;
        end
        default: begin
        end
      endcase
    end else if (req && !WE_I) begin
      unique case (ADR_I)
        rdem_pkg::REG_CTRL: begin
          st_nxt.dat[rdem_pkg::CTRL_GUARD_LSB +: rdem_pkg::GUARD_W] = st_r.guard;
        end
        rdem_pkg::REG_STAT: begin
          st_nxt.dat = lane_field(lim_v, rdem_pkg::FLD_LIMIT_LSB)
                     | lane_field(st_r.early, rdem_pkg::FLD_EARLY_LSB)
                     | lane_field(st_r.late, rdem_pkg::FLD_LATE_LSB);
        end
        rdem_pkg::REG_IRQ_STAT: begin
          st_nxt.dat = st_r.irq_stat;
        end
        rdem_pkg::REG_IRQ_MASK: begin
          st_nxt.dat = st_r.irq_mask;
        end
        default: begin
          // Tap words follow the base; anything else reads zero
          if (ADR_I >= rdem_pkg::REG_TAP_BASE && ADR_I[1:0] == 2'h0) begin
            idx = int'(ADR_I - rdem_pkg::REG_TAP_BASE) / 4;
            if (idx < LANES) begin
              st_nxt.dat[TAP_W-1:0] = tap_v[idx*TAP_W +: TAP_W];
            end
          end
        end
      endcase
    end

    // Sticky status, set beats write-one-to-clear
    st_nxt.irq_stat = ((st_r.irq_stat & ~w1c) | ev) & valid;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // ============================================================
  // Registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '{
        step_m: '0,
        step_s: '0,
        step_q: '0,
        dir_m: '0,
        dir_s: '0,
        early: '0,
        late: '0,
        lim_q: INIT_LIMS,
        guard: rdem_pkg::GUARD_RST,
        irq_stat: 32'h0000_0000,
        irq_mask: rdem_pkg::IRQ_MASK_RST,
        irq: 1'b0,
        ack: 1'b0,
        dat: 32'h0000_0000
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign DAT_O = st_r.dat;
  assign ACK_O = st_r.ack;
  assign TAP_LIMIT_HIT = lim_v; // [RQ4]
  assign EYE_EARLY = st_r.early;
  assign EYE_LATE = st_r.late;
  assign IRQ = st_r.irq;

endmodule // rdem_top

// ### rdem_props.sv
/*
  Port checker for the delay and eye monitor block, lane 0.
  Assumes it is bound to rdem_top and sees only its ports.
*/
module rdem_props #(
  parameter int LANES = 4,
  parameter int OFS_W = 5
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // Delay and eye
  input wire logic [LANES-1:0] TAP_STEP,
  input wire logic [LANES-1:0] TAP_RESTORE,
  input wire logic [LANES-1:0] TAP_LIMIT_HIT,
  input wire logic [LANES-1:0] EDGE_VLD,
  input wire logic [LANES*OFS_W-1:0] EDGE_OFS,
  input wire logic [LANES-1:0] FLAG_CLR,
  input wire logic [LANES-1:0] EYE_EARLY,
  input wire logic [LANES-1:0] EYE_LATE
);
  // ==========
  // Checks
  logic signed [OFS_W-1:0] ofs0;
  assign ofs0 = EDGE_OFS[OFS_W-1:0];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  a_ack_answers: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
  a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data not zero");
  a_late_zero_hit: assert property (EDGE_VLD[0] && ofs0 == 0 |=> EYE_LATE[0])
    else $error("late flag missing");
  a_early_far_none: assert property (EDGE_VLD[0] && ofs0 < -8 && !EYE_EARLY[0] |=>
    !EYE_EARLY[0]) else $error("early flag on far edge");
  a_late_far_none: assert property (EDGE_VLD[0] && ofs0 >= 8 && !EYE_LATE[0] |=>
    !EYE_LATE[0]) else $error("late flag on far edge");
  a_flag_clear: assert property (FLAG_CLR[0] && !EDGE_VLD[0] |=>
    !EYE_EARLY[0] && !EYE_LATE[0]) else $error("flags not cleared");
  a_early_sticky: assert property (EYE_EARLY[0] && !FLAG_CLR[0] |=> EYE_EARLY[0])
    else $error("early flag dropped");
  // Limit moves only three edges after a step rise, or by restore
  a_limit_cause: assert property ($changed(TAP_LIMIT_HIT[0]) |->
    ($past(TAP_STEP[0], 3) && !$past(TAP_STEP[0], 4)) || TAP_RESTORE[0] ||
    $past(TAP_RESTORE[0])) else $error("limit changed without cause");
  cover property ($rose(EYE_EARLY[0]));
  cover property ($rose(EYE_LATE[0]));
  cover property ($rose(TAP_LIMIT_HIT[0]));
endmodule // rdem_props

bind rdem_top rdem_props #(.LANES(LANES), .OFS_W(OFS_W)) u_props (
  .MCLK(MCLK), .RESETN(RESETN), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .TAP_STEP(TAP_STEP), .TAP_RESTORE(TAP_RESTORE),
  .TAP_LIMIT_HIT(TAP_LIMIT_HIT), .EDGE_VLD(EDGE_VLD), .EDGE_OFS(EDGE_OFS),
  .FLAG_CLR(FLAG_CLR), .EYE_EARLY(EYE_EARLY), .EYE_LATE(EYE_LATE));

// ### rdem_trainer.sv
/*
  Fabric training logic model: answers a lane 0 flag with one step, then a clear.
  Assumes the same clock as the block; other lanes stay idle.
*/
module rdem_trainer #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Flags in, controls out
  input wire logic [LANES-1:0] early,
  input wire logic [LANES-1:0] late,
  output logic [LANES-1:0] step,
  output logic [LANES-1:0] dir,
  output logic [LANES-1:0] clr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    step = '0;
    dir = '0;
    clr = '0;
    forever begin
      @(posedge clk);
      if (rst_n && (early[0] || late[0])) begin
        dir[0] <= late[0];
        repeat (2) @(posedge clk);
        step[0] <= 1'b1;
        repeat (2) @(posedge clk);
        step[0] <= 1'b0;
        // Clear only once the new tap has landed
        repeat (4) @(posedge clk);
        clr[0] <= 1'b1;
        @(posedge clk);
        clr[0] <= 1'b0;
        @(posedge clk);
      end
    end
  end
endmodule // rdem_trainer

// ### rdem_top_tb.sv
/*
  Self-checking bench for rdem_top with a 3-bit chain.
  Assumes the trainer model drives steps, directions and clears; bench drives the rest.
*/
module rdem_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals
  localparam logic [2:0] INIT = 3'h2;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o, q;
  logic ack, irq;
  logic [3:0] step, dir, clr, lim, early, late;
  logic [3:0] rst_tap = 4'h0;
  logic [3:0] vld = 4'h0;
  logic [19:0] ofs = 20'h0;
  int mismatches = 0;
  int check_count = 0;
  int tap;
  always #2.5 mclk = ~mclk;
  rdem_top #(.TAP_W(3), .INIT_TAP(INIT)) u_dut (.MCLK(mclk), .RESETN(resetn),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat),
    .DAT_O(dat_o), .ACK_O(ack), .TAP_STEP(step), .TAP_DIR(dir), .TAP_RESTORE(rst_tap),
    .TAP_LIMIT_HIT(lim), .EDGE_VLD(vld), .EDGE_OFS(ofs), .FLAG_CLR(clr),
    .EYE_EARLY(early), .EYE_LATE(late), .IRQ(irq));
  rdem_trainer #(.LANES(4)) u_trainer (.clk(mclk), .rst_n(resetn), .early(early),
    .late(late), .step(step), .dir(dir), .clr(clr));
  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("wb ack", 32'h1, {31'h0, ack});
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rep(input logic [4:0] o);
    vld[0] <= 1'b1;
    ofs[4:0] <= o;
    @(posedge mclk);
    vld[0] <= 1'b0;
    @(posedge mclk);
  endtask
  // Bounded wait for the trainer to finish its step and clear
  task automatic settle();
    int n;
    n = 0;
    while ((early[0] | late[0]) !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("flags", 32'h0, {early[0], late[0]});
    repeat (6) @(posedge mclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h0, q);
    wb(1'b0, 8'h0C, 32'h0);
    chk("mask", 32'h0, q);
    wb(1'b0, 8'h10, 32'h0);
    chk("tap init", 32'(INIT), q);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("limit init", 32'h0, lim[0]);
    $display("t_regs done");
  endtask
  task automatic t_guard();
    int sp [8] = '{1, 2, 3, 4, 5, 6, 8, 8};
    tap = INIT;
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 8'h00, c);
      rep(5'(sp[c]));
      chk("far late", 32'h0, late[0]);
      settle();
      rep(5'(sp[c] - 1));
      chk("near late", 32'h1, late[0]);
      settle();
      tap = (tap < 7) ? tap + 1 : 7;
      wb(1'b0, 8'h10, 32'h0);
      chk("tap up", tap, q);
    end
    chk("limit max", 32'h1, lim[0]);
    $display("t_guard done");
  endtask
  task automatic t_early();
    rep(5'h18);
    rep(5'h17);
    chk("far early", 32'h0, early[0]);
    for (int i = 0; i < 8; i++) begin
      rep(5'h19);
      chk("near early", 32'h1, early[0]);
      settle();
      tap = (tap > 0) ? tap - 1 : 0;
      wb(1'b0, 8'h10, 32'h0);
      chk("tap down", tap, q);
      if (i == 0) chk("limit off", 32'h0, lim[0]);
    end
    chk("limit min", 32'h1, lim[0]);
    $display("t_early done");
  endtask
  task automatic t_restore();
    rst_tap[0] <= 1'b1;
    @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk("tap restore", 32'(INIT), q);
    chk("limit restore", 32'h0, lim[0]);
    rst_tap[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("t_restore done");
  endtask
  task automatic t_irq();
    wb(1'b1, 8'h0C, 32'h100);
    wb(1'b1, 8'h08, 32'hFFFFFFFF);
    rep(5'h19);
    chk("irq set", 32'h1, irq);
    wb(1'b0, 8'h08, 32'h0);
    chk("irq stat", 32'h100, q);
    wb(1'b0, 8'h04, 32'h0);
    chk("stat", 32'h100, q);
    settle();
    wb(1'b1, 8'h08, 32'h100);
    chk("irq clear", 32'h0, irq);
    wb(1'b1, 8'h0C, 32'h0);
    rep(5'h19);
    chk("irq masked", 32'h0, irq);
    settle();
    $display("t_irq done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_guard();
    t_early();
    t_restore();
    t_irq();
    tally_and_finish();
  end
  // Whole run is well under a thousand cycles, far below the 20000-cycle limit
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule // rdem_top_tb
